// ---- hw/sdram_ctl_end.sv ----
// Controller end of the SDRAM link with an AXI4-Lite register slave.
// Assumes software orders one command at a time and keeps bank timing itself.
module sdram_ctl_end
	import sdram_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	sdram_link_if.ctl        lk
);
	ctl_state_t        st_q;
	logic [7:0]        awa_q;
	logic [31:0]       wd_q, wdreg_q, rd_q;
	logic [3:0]        ws_q, dqmreg_q;
	logic [16:0]       cmdw_q;
	logic              pend_q, sr_q, due_q;
	logic [MODE_W-1:0] mode_q;
	logic [9:0]        tmr_q;
	logic [3:0]        wait_q;
	logic [8:0]        left_q;
	logic              wfire, cmd_wr;
	logic [31:0]       smask;
	op_t               op;
	logic [AW-1:0]     mr;

	assign wfire  = !awready && !wready && !bvalid;
	assign cmd_wr = wfire && awa_q == REG_CMD;
	assign op     = op_t'(cmdw_q[3:0]);
	assign smask  = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

	// Mode word sent: test bits normal, latency from access time
	always_comb begin
		mr = cmdw_q[16:6];
		mr[MR_TM_LSB +: 2] = TM_NORMAL;
		mr[MR_CL_LSB +: 3] = CL_CODE;
	end

	// AXI write channels, either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			awa_q   <= 8'h00;
			wd_q    <= '0;
			ws_q    <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awa_q   <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wd_q   <= wdata;
				ws_q   <= wstrb;
				wready <= 1'b0;
			end
			if (wfire) begin
				bvalid <= 1'b1;
				bresp  <= (awa_q == REG_CMD || awa_q == REG_WDATA || awa_q == REG_DQM) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Writable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdreg_q  <= '0;
			dqmreg_q <= 4'h0;
			cmdw_q   <= '0;
		end else if (wfire) begin
			if (awa_q == REG_WDATA) begin
				wdreg_q <= (wdreg_q & ~smask) | (wd_q & smask);
			end else if (awa_q == REG_DQM && ws_q[0]) begin
				dqmreg_q <= wd_q[3:0];
			end else if (awa_q == REG_CMD && !pend_q) begin
				cmdw_q <= wd_q[16:0];
			end
		end
	end

	// AXI read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= RESP_OKAY;
			if (araddr == REG_STATUS) begin
				rdata <= {19'h0, mode_q, sr_q, st_q == C_SLEEP, pend_q || st_q != C_IDLE};
			end else if (araddr == REG_RDATA) begin
				rdata <= rd_q;
			end else if (araddr == REG_WDATA) begin
				rdata <= wdreg_q;
			end else begin
				rdata <= '0;
				rresp <= RESP_SLVERR;
			end
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Refresh timer; due set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn || sr_q) begin
			tmr_q <= 10'h000;
			due_q <= 1'b0;
		end else begin
			if (tmr_q == 10'(REF_INTERVAL_CYC - 1)) begin
				tmr_q <= 10'h000;
				due_q <= 1'b1;
			end else begin
				tmr_q <= tmr_q + 10'h001;
				if (st_q == C_REF && wait_q == 4'h0) begin
					due_q <= 1'b0;
				end
			end
		end
	end

	// Last word read back from the memory
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q <= '0;
		end else if (|lk.mem_dq_oe) begin
			rd_q <= lk.mem_dq;
		end
	end

	// Command sequencer driving the link
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= C_IDLE;
			{lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} <= {1'b1, CMD_NOP};
			lk.cke <= 1'b1;
			lk.ba <= 2'h0;
			lk.addr <= '0;
			lk.dqm <= 4'hf;
			lk.ctl_dq <= '0;
			lk.ctl_dq_oe <= 1'b0;
			pend_q <= 1'b0;
			sr_q <= 1'b0;
			mode_q <= MODE_RESET;
			wait_q <= 4'h0;
			left_q <= 9'h000;
		end else begin
			{lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} <= {1'b0, CMD_NOP};
			lk.dqm <= dqmreg_q;
			lk.ctl_dq_oe <= left_q != 9'h000;
			if (left_q != 9'h000) begin
				left_q <= left_q - 9'h001;
			end
			if (cmd_wr && !pend_q) begin
				pend_q <= 1'b1;
			end
			case (st_q)
				C_IDLE: begin
					if (due_q) begin
						{lk.ras_n, lk.cas_n, lk.we_n} <= CMD_PRE;
						lk.addr[AP_BIT] <= 1'b1;
						wait_q <= 4'(TRP_CYC - 1);
						st_q <= C_REF;
					end else if (pend_q && op != OP_WAKE) begin
						pend_q <= 1'b0;
						lk.ba <= cmdw_q[5:4];
						lk.addr <= cmdw_q[16:6];
						case (op)
							OP_MRS: begin
								{lk.ras_n, lk.cas_n, lk.we_n} <= CMD_MRS;
								lk.addr <= mr;
								mode_q <= mr[MODE_W-1:0];
								wait_q <= 4'(TMRS_CYC - 1);
								st_q <= C_GAP;
							end
							OP_ACT: {lk.ras_n, lk.cas_n, lk.we_n} <= CMD_ACT;
							OP_READ: {lk.ras_n, lk.cas_n, lk.we_n} <= CMD_READ;
							OP_PRE: {lk.ras_n, lk.cas_n, lk.we_n} <= CMD_PRE;
							OP_STOP: begin
								{lk.ras_n, lk.cas_n, lk.we_n} <= CMD_STOP;
								left_q <= 9'h000;
								lk.ctl_dq_oe <= 1'b0;
							end
							OP_WRITE: begin
								{lk.ras_n, lk.cas_n, lk.we_n} <= CMD_WRITE;
								lk.ctl_dq <= wdreg_q;
								lk.ctl_dq_oe <= 1'b1;
								left_q <= (mode_q[MR_WBL_BIT] ? 9'h001 : bl_words(mode_q[2:0])) - 9'h001;
							end
							OP_SELF: begin
								// Distributed refresh keeps rows fresh, no burst needed here
								{lk.ras_n, lk.cas_n, lk.we_n} <= CMD_REF;
								lk.cke <= 1'b0;
								sr_q <= 1'b1;
								st_q <= C_SLEEP;
							end
							OP_SLEEP: begin
								lk.cke <= 1'b0;
								st_q <= C_SLEEP;
							end
							default: ;
						endcase
					end else if (pend_q) begin
						pend_q <= 1'b0;
					end
				end
				C_GAP: begin
					if (wait_q == 4'h0) begin
						st_q <= C_IDLE;
					end else begin
						wait_q <= wait_q - 4'h1;
					end
				end
				C_REF: begin
					if (wait_q == 4'h0) begin
						{lk.ras_n, lk.cas_n, lk.we_n} <= CMD_REF;
						wait_q <= 4'(TRC_CYC - 1);
						st_q <= C_GAP;
					end else begin
						wait_q <= wait_q - 4'h1;
					end
				end
				C_SLEEP: begin
					if ((pend_q && op == OP_WAKE) || (!sr_q && due_q)) begin
						lk.cke <= 1'b1;
						wait_q <= sr_q ? 4'(TRC_CYC - 1) : 4'(TPDE_CYC);
						sr_q <= 1'b0;
						st_q <= C_GAP;
						if (pend_q && op == OP_WAKE) begin
							pend_q <= 1'b0;
						end
					end
				end
				default: st_q <= C_IDLE;
			endcase
		end
	end
endmodule : sdram_ctl_end

// ---- hw/sdram_pkg.sv ----
// Shared constants for the SDRAM link: command codes, mode fields, timing.
// Assumes a single 50 MHz clock shared by both ends of the link.
package sdram_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int DW            = 32;
	localparam int AW            = 11;
	localparam int MODE_W        = 10;

	// Command code {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_MRS   = 3'h0;
	localparam logic [2:0] CMD_REF   = 3'h1;
	localparam logic [2:0] CMD_PRE   = 3'h2;
	localparam logic [2:0] CMD_ACT   = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ  = 3'h5;
	localparam logic [2:0] CMD_STOP  = 3'h6;
	localparam logic [2:0] CMD_NOP   = 3'h7;

	// Mode register field positions
	localparam int MR_BL_LSB  = 0;
	localparam int MR_BT_BIT  = 3;
	localparam int MR_CL_LSB  = 4;
	localparam int MR_TM_LSB  = 7;
	localparam int MR_WBL_BIT = 9;
	localparam int AP_BIT     = 10;
	localparam logic [MODE_W-1:0] MODE_RESET = 10'h022;

	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [2:0] CL_2    = 3'h2;
	localparam logic [2:0] CL_3    = 3'h3;
	localparam logic [1:0] TM_NORMAL = 2'h0;

	// Refresh and recovery timing
	localparam int REF_PERIOD_NS    = 64000000;
	localparam int REF_COUNT        = 4096;
	localparam int REF_INTERVAL_CYC = REF_PERIOD_NS / REF_COUNT / CLK_PERIOD_NS;
	localparam int TRC_NS           = 80;
	localparam int TRC_CYC          = (TRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRP_NS           = 24;
	localparam int TRP_CYC          = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMRS_CYC         = 2;
	localparam int TPDE_CYC         = 1;
	localparam int TCAC_NS          = 30;
	localparam int CL_RAW           = (TCAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CL_CYC           = (CL_RAW < 2) ? 2 : CL_RAW;
	localparam logic [2:0] CL_CODE  = 3'(CL_CYC);

	// Controller register offsets
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_WDATA  = 8'h04;
	localparam logic [7:0] REG_DQM    = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Command register orders
	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_MRS = 4'h1, OP_ACT = 4'h2, OP_READ = 4'h3,
		OP_WRITE = 4'h4, OP_PRE = 4'h5, OP_STOP = 4'h6, OP_SELF = 4'h7,
		OP_WAKE = 4'h8, OP_SLEEP = 4'h9
	} op_t;

	typedef enum logic [1:0] {ST_RUN = 2'b00, ST_PDOWN = 2'b01, ST_SELF = 2'b10} mem_state_t;
	typedef enum logic [1:0] {C_IDLE = 2'b00, C_GAP = 2'b01, C_SLEEP = 2'b11, C_REF = 2'b10} ctl_state_t;

	// Words in one burst for a length code; full page counts 256
	function automatic logic [8:0] bl_words(input logic [2:0] code);
		case (code)
			BL_1:    bl_words = 9'h001;
			BL_2:    bl_words = 9'h002;
			BL_4:    bl_words = 9'h004;
			BL_8:    bl_words = 9'h008;
			default: bl_words = 9'h100;
		endcase
	endfunction : bl_words
endpackage : sdram_pkg

// ---- hw/sdram_link_if.sv ----
// Command, clock enable and data lines between controller and memory.
// Both ends run on the same clock; data runs on separate ctl_dq and mem_dq lines.
interface sdram_link_if;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic        cke;
	logic [1:0]  ba;
	logic [10:0] addr;
	logic [3:0]  dqm;
	logic [31:0] ctl_dq;
	logic        ctl_dq_oe;
	logic [31:0] mem_dq;
	logic [3:0]  mem_dq_oe;

	modport mem (input cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, ctl_dq, ctl_dq_oe,
		output mem_dq, mem_dq_oe);
	modport ctl (output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, ctl_dq, ctl_dq_oe,
		input mem_dq, mem_dq_oe);
endinterface : sdram_link_if

// ---- hw/sdram_mem_end.sv ----
// Memory end of the SDRAM link: command decode, mode, bursts, refresh, power states.
// Assumes a user array answering arr_rdata in the same cycle as the address.
// Behaviour
// - Burst order bit: 0 sequential, 1 interleaved
// - Sequential columns increment, wrapping at 8 bits
// - Interleaved column is start XOR word index
// - Latency code 010 is 2, 011 is 3
// - Controller picks smallest latency covering access time
// - Controller writes test bits as 00
// - Write single select forces one-word writes
// - NOP registers nothing new
// - Burst stop ends only non-autoprecharge bursts
// - Stopped read drains for latency cycles
// - Chip select high ignores all command inputs
// - Refresh uses internal counter, counter advances
// - Controller refreshes 4096 times per 64 ms
// - Refresh needs idle banks, then NOP gap
// - Refresh with CKE low enters self refresh
// - Self refresh exit: CKE high, NOPs tRC
// - Refresh bursts around self refresh if bursting
// - CKE low mid-burst freezes state next cycle
// - CKE low when idle enters power-down
// - Controller limits suspend and power-down to 64 ms
// - CKE high resumes; wait one clock
// - Byte mask blocks writes, floats read bytes
// - Read mask latency two, write mask immediate
// - Length code 000/001/010/011/111 gives 1/2/4/8/page
module sdram_mem_end
	import sdram_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	sdram_link_if.mem        lk,
	output logic             arr_we,
	output logic             arr_re,
	output logic [1:0]       arr_ba,
	output logic [AW-1:0]    arr_row,
	output logic [7:0]       arr_col,
	output logic [3:0]       arr_be,
	output logic [DW-1:0]    arr_wdata,
	input  wire logic [DW-1:0] arr_rdata,
	output logic             ref_pulse,
	output logic [11:0]      ref_row,
	output logic             power_down,
	output logic             self_ref
);
	mem_state_t        st_q;
	logic              cke_q;
	logic [MODE_W-1:0] mode_q;
	logic [AW-1:0]     row_q [4];
	logic [3:0]        open_q;
	logic              on_q, wr_q, ap_q, full_q;
	logic [1:0]        ba_q;
	logic [7:0]        start_q, k_q;
	logic [8:0]        len_q;
	logic [DW-1:0]     p1_q;
	logic              p1v_q, dv_q;
	logic [3:0]        dqm_q;
	logic [11:0]       ref_ctr_q;
	logic [9:0]        sr_tmr_q;

	logic [2:0]  cmd;
	logic        sel, tick, go, rw_cmd, stop_hit, issue_new, issue_cont, last, idle, cl3;
	logic [2:0]  bl_code;
	logic [8:0]  nlen;
	logic [7:0]  col;

	// Command decode; internal clock runs if CKE was high last edge
	assign cmd       = {lk.ras_n, lk.cas_n, lk.we_n};
	assign tick      = cke_q;
	assign sel       = ~lk.cs_n && st_q == ST_RUN;
	assign go        = sel && tick && cmd != CMD_NOP;
	assign rw_cmd    = go && (cmd == CMD_READ || cmd == CMD_WRITE);
	assign stop_hit  = go && cmd == CMD_STOP && on_q && !ap_q;
	assign issue_new = rw_cmd;
	assign issue_cont = tick && on_q && !stop_hit && !rw_cmd;
	assign last      = on_q && !full_q && {1'b0, k_q} == len_q - 9'h001;
	assign idle      = ~|open_q && !on_q;
	assign cl3       = mode_q[MR_CL_LSB +: 3] == CL_3;
	assign bl_code   = mode_q[MR_BL_LSB +: 3];

	// Words in the new burst; single-word writes when selected
	assign nlen = (cmd == CMD_WRITE && mode_q[MR_WBL_BIT]) ? 9'h001 : bl_words(bl_code);

	// Column of the current word
	always_comb begin
		if (mode_q[MR_BT_BIT] && !full_q) begin
			col = start_q ^ k_q;
		end else begin
			col = start_q + k_q;
		end
	end

	// Clock enable seen by the internal clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cke_q <= 1'b1;
		end else begin
			cke_q <= lk.cke;
		end
	end

	// Power state: self refresh, power-down, running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_RUN;
		end else begin
			case (st_q)
				ST_RUN: begin
					if (sel && cke_q && !lk.cke && cmd == CMD_REF && idle) begin
						st_q <= ST_SELF;
					end else if (cke_q && !lk.cke && idle) begin
						st_q <= ST_PDOWN;
					end
				end
				ST_SELF: begin
					if (lk.cke) begin
						st_q <= ST_RUN;
					end
				end
				ST_PDOWN: begin
					if (lk.cke) begin
						st_q <= ST_RUN;
					end
				end
				default: st_q <= ST_RUN;
			endcase
		end
	end

	// Power flags are state bits
	assign power_down = st_q[0];
	assign self_ref   = st_q[1];

	// Mode register, loaded only while all banks idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= MODE_RESET;
		end else if (go && cmd == CMD_MRS && idle) begin
			mode_q <= lk.addr[MODE_W-1:0];
		end
	end

	// Open rows per bank; autoprecharge closes at end of 2, 4 and 8 word bursts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			open_q <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				row_q[i] <= '0;
			end
		end else begin
			if (go && cmd == CMD_ACT) begin
				open_q[lk.ba] <= 1'b1;
				row_q[lk.ba]  <= lk.addr;
			end else if (go && cmd == CMD_PRE) begin
				if (lk.addr[AP_BIT]) begin
					open_q <= 4'h0;
				end else begin
					open_q[lk.ba] <= 1'b0;
				end
			end else if (tick && last && ap_q && !rw_cmd) begin
				open_q[ba_q] <= 1'b0;
			end
		end
	end

	// Burst engine; frozen while the internal clock is masked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_q    <= 1'b0;
			wr_q    <= 1'b0;
			ap_q    <= 1'b0;
			full_q  <= 1'b0;
			ba_q    <= 2'h0;
			start_q <= 8'h00;
			k_q     <= 8'h00;
			len_q   <= 9'h001;
		end else if (tick) begin
			if (issue_new) begin
				on_q    <= nlen != 9'h001;
				wr_q    <= cmd == CMD_WRITE;
				ap_q    <= lk.addr[AP_BIT];
				full_q  <= nlen == 9'h100 && !(cmd == CMD_WRITE && mode_q[MR_WBL_BIT]);
				ba_q    <= lk.ba;
				start_q <= lk.addr[7:0];
				k_q     <= 8'h01;
				len_q   <= nlen;
			end else if (stop_hit) begin
				on_q <= 1'b0;
			end else if (on_q) begin
				k_q <= k_q + 8'h01;
				if (last) begin
					on_q <= 1'b0;
				end
			end
		end
	end

	// Array access; write data and mask from one edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arr_we    <= 1'b0;
			arr_re    <= 1'b0;
			arr_ba    <= 2'h0;
			arr_row   <= '0;
			arr_col   <= 8'h00;
			arr_be    <= 4'h0;
			arr_wdata <= '0;
		end else if (tick) begin
			if (issue_new) begin
				arr_ba  <= lk.ba;
				arr_row <= row_q[lk.ba];
				arr_col <= lk.addr[7:0];
			end else if (issue_cont) begin
				arr_ba  <= ba_q;
				arr_row <= row_q[ba_q];
				arr_col <= col;
			end
			arr_we    <= issue_new ? cmd == CMD_WRITE : issue_cont && wr_q;
			arr_re    <= issue_new ? cmd == CMD_READ : issue_cont && !wr_q;
			arr_wdata <= lk.ctl_dq;
			arr_be    <= ~lk.dqm;
		end else begin
			arr_we <= 1'b0;
		end
	end

	// Read output pipe: one stage for latency 2, two for latency 3
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p1_q      <= '0;
			p1v_q     <= 1'b0;
			dv_q      <= 1'b0;
			dqm_q     <= 4'hf;
			lk.mem_dq <= '0;
			lk.mem_dq_oe <= 4'h0;
		end else begin
			if (tick) begin
				p1_q      <= arr_rdata;
				p1v_q     <= arr_re;
				dv_q      <= cl3 ? p1v_q : arr_re;
				lk.mem_dq <= cl3 ? p1_q : arr_rdata;
				dqm_q     <= lk.dqm;
				lk.mem_dq_oe <= {4{cl3 ? p1v_q : arr_re}} & ~dqm_q;
			end
			if (st_q != ST_RUN) begin
				lk.mem_dq_oe <= 4'h0;
			end
		end
	end

	// Refresh counter, commanded and self-timed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_ctr_q <= 12'h000;
			sr_tmr_q  <= 10'h000;
			ref_pulse <= 1'b0;
			ref_row   <= 12'h000;
		end else begin
			ref_pulse <= 1'b0;
			if (go && cmd == CMD_REF && lk.cke) begin
				ref_pulse <= 1'b1;
				ref_row   <= ref_ctr_q;
				ref_ctr_q <= ref_ctr_q + 12'h001;
			end
			if (st_q == ST_SELF) begin
				if (sr_tmr_q == 10'(REF_INTERVAL_CYC - 1)) begin
					sr_tmr_q  <= 10'h000;
					ref_pulse <= 1'b1;
					ref_row   <= ref_ctr_q;
					ref_ctr_q <= ref_ctr_q + 12'h001;
				end else begin
					sr_tmr_q <= sr_tmr_q + 10'h001;
				end
			end else begin
				sr_tmr_q <= 10'h000;
			end
		end
	end
endmodule : sdram_mem_end

// ---- bench/sdram_link_assertions.sv ----
// Link checks between the two ends of the SDRAM link.
// Assumes one clock; link signals arrive as plain inputs.
module sdram_link_assertions
	import sdram_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        cke,
	input wire logic [10:0] addr,
	input wire logic [3:0]  dqm,
	input wire logic [3:0]  mem_dq_oe
);
	localparam int REF_LIMIT = REF_INTERVAL_CYC + 300;
	logic [2:0]  cmd;
	logic        taken, cke_q, ap_q, self_q;
	logic [15:0] since_ref_q;

	// Command registered by the memory
	assign cmd   = {ras_n, cas_n, we_n};
	assign taken = !cs_n && cke_q && !self_q;

	// Last clock enable, burst autoprecharge, self refresh
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cke_q  <= 1'b1;
			ap_q   <= 1'b0;
			self_q <= 1'b0;
		end else begin
			cke_q <= cke;
			if (taken && (cmd == CMD_READ || cmd == CMD_WRITE)) ap_q <= addr[AP_BIT];
			if (taken && cmd == CMD_REF && !cke) self_q <= 1'b1;
			else if (cke) self_q <= 1'b0;
		end
	end

	// Cycles since last refresh; clear in self refresh
	always_ff @(posedge aclk) begin
		if (!aresetn || self_q || (taken && cke && cmd == CMD_REF)) since_ref_q <= 16'h0000;
		else since_ref_q <= since_ref_q + 16'h0001;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_read_latency: assert property (taken && cmd == CMD_READ && dqm == 4'h0 |-> ##2 mem_dq_oe == 4'hf)
		else $error("read latency");
	a_mask_float: assert property (mem_dq_oe != 4'h0 |-> (mem_dq_oe & $past(dqm, 2)) == 4'h0)
		else $error("mask float");
	a_stop_drain: assert property (taken && cmd == CMD_STOP && !ap_q |-> ##3 mem_dq_oe == 4'h0)
		else $error("stop drain");
	a_self_quiet: assert property (self_q |-> mem_dq_oe == 4'h0)
		else $error("self refresh drive");
	a_self_exit: assert property ($fell(self_q) |-> (cs_n || cmd == CMD_NOP) [*3])
		else $error("self exit gap");
	a_wake_gap: assert property ($rose(cke) |-> cs_n || cmd == CMD_NOP)
		else $error("wake gap");
	a_ref_quiet: assert property (taken && cke && cmd == CMD_REF |=> (cs_n || cmd == CMD_NOP) [*3])
		else $error("refresh gap");
	a_test_bits: assert property (taken && cmd == CMD_MRS |-> addr[8:7] == TM_NORMAL)
		else $error("test bits");
	a_latency_code: assert property (taken && cmd == CMD_MRS |-> addr[6:4] == CL_CODE)
		else $error("latency code");
	a_refresh_due: assert property (since_ref_q <= 16'(REF_LIMIT))
		else $error("refresh overdue");
endmodule : sdram_link_assertions

// ---- bench/sdram_mode_refresh_power_cmds_tb_top.sv ----
// Bench: both SDRAM link ends joined, driven over AXI4-Lite.
// Assumes a word array model answering in the same cycle as the address.
module sdram_mode_refresh_power_cmds_tb_top
	import sdram_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [9:0] mode; logic wr; logic [7:0] col; logic [3:0] dqm;} row_t;
	logic          aclk;
	logic          aresetn = 1'b0;
	logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]   wdata = 32'h0, rdata, d;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp, r;
	logic          arr_we, arr_re, ref_pulse, power_down, self_ref;
	logic [1:0]    arr_ba;
	logic [AW-1:0] arr_row;
	logic [7:0]    arr_col, last;
	logic [3:0]    arr_be, be_seen;
	logic [DW-1:0] arr_wdata, arr_rdata;
	logic [11:0]   ref_row, row_prev;
	logic [31:0]   arr [0:1023];
	logic [7:0]    col_q [$], wcol_q [$];
	int            num_errors = 0, num_checks = 0, cyc = 0, refs = 0, base;
	row_t          rows [10] = '{'{10'h022, 1'b0, 8'hfe, 4'h0}, '{10'h02b, 1'b0, 8'h05, 4'h0},
		'{10'h02a, 1'b0, 8'h0a, 4'h0}, '{10'h021, 1'b0, 8'hff, 4'h0}, '{10'h020, 1'b0, 8'h10, 4'h0},
		'{10'h023, 1'b0, 8'hfc, 4'h0}, '{10'h022, 1'b0, 8'h20, 4'h6}, '{10'h022, 1'b1, 8'h30, 4'h5},
		'{10'h222, 1'b1, 8'h40, 4'h0}, '{10'h02a, 1'b1, 8'h06, 4'h9}};

	sdram_link_if lk ();
	sdram_ctl_end i_sdram_ctl_end (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .lk(lk.ctl));
	sdram_mem_end i_sdram_mem_end (.aclk(aclk), .aresetn(aresetn), .lk(lk.mem), .arr_we(arr_we),
		.arr_re(arr_re), .arr_ba(arr_ba), .arr_row(arr_row), .arr_col(arr_col), .arr_be(arr_be),
		.arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .ref_pulse(ref_pulse), .ref_row(ref_row),
		.power_down(power_down), .self_ref(self_ref));
	sdram_link_assertions i_sdram_link_assertions (.aclk(aclk), .aresetn(aresetn), .cs_n(lk.cs_n),
		.ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .cke(lk.cke), .addr(lk.addr), .dqm(lk.dqm),
		.mem_dq_oe(lk.mem_dq_oe));

	// Free-running 50 MHz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Array model, logs, timeout
	assign arr_rdata = arr[{arr_ba, arr_col}];
	always @(posedge aclk) begin
		if (arr_re) col_q.push_back(arr_col);
		if (arr_we) begin
			wcol_q.push_back(arr_col);
			be_seen = arr_be;
			for (int b = 0; b < 4; b++) if (arr_be[b]) arr[{arr_ba, arr_col}][8*b+:8] = arr_wdata[8*b+:8];
		end
		if (ref_pulse) begin
			if (refs > 0) check("ref_row", 32'(ref_row), 32'(12'(row_prev + 12'h001)));
			row_prev = ref_row;
			refs++;
		end
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		if (num_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= v;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// One order, then poll until idle, or asleep for a sleep order
	task automatic cmd(input op_t op, input logic [1:0] ba, input logic [10:0] a);
		logic [31:0] s;
		logic [1:0]  e;
		axi_wr(REG_CMD, {15'h0000, a, ba, op}, e);
		do axi_rd(REG_STATUS, s, e); while (s[1:0] !== {2{op inside {OP_SLEEP, OP_SELF}}});
	endtask : cmd

	// Precharge, mode, activate, access, wait quiet
	task automatic run(input logic [9:0] mode, input op_t op, input logic [10:0] a, input logic stop);
		int q;
		cmd(OP_PRE, 2'h0, 11'h400);
		cmd(OP_MRS, 2'h0, {1'b0, mode});
		cmd(OP_ACT, 2'h1, 11'h012);
		col_q.delete();
		wcol_q.delete();
		cmd(op, 2'h1, a);
		if (stop) cmd(OP_STOP, 2'h1, 11'h000);
		q = 0;
		for (int i = 0; i < 400 && q < 8; i++) begin
			@(posedge aclk);
			q = (arr_re || arr_we) ? 0 : q + 1;
		end
	endtask : run

	task automatic expect_cols(input logic [9:0] mode, input logic [7:0] c0, input logic wr, output logic [7:0] e);
		int n;
		n = (mode[2:0] == BL_FULL) ? 256 : (1 << mode[2:0]);
		if (wr && mode[MR_WBL_BIT]) n = 1;
		check("words", 32'(wr ? wcol_q.size() : col_q.size()), 32'(n));
		for (int k = 0; k < n; k++) begin
			e = (mode[MR_BT_BIT] && mode[2:0] != BL_FULL) ? c0 ^ 8'(k) : c0 + 8'(k);
			check("column", {24'h0, wr ? wcol_q[k] : col_q[k]}, {24'h0, e});
		end
	endtask : expect_cols

	// Reset, burst table, then stop, refresh, power
	initial begin
		for (int i = 0; i < 1024; i++) arr[i] = 32'h5a000000 + 32'(i);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(REG_STATUS, d, r);
		check("reset mode", 32'(d[12:3]), 32'(MODE_RESET));
		axi_wr(REG_WDATA, 32'hc3a596e1, r);
		foreach (rows[i]) begin
			axi_wr(REG_DQM, {28'h0, rows[i].dqm}, r);
			run(rows[i].mode, rows[i].wr ? OP_WRITE : OP_READ, {3'h0, rows[i].col}, 1'b0);
			expect_cols(rows[i].mode, rows[i].col, rows[i].wr, last);
			axi_rd(REG_RDATA, d, r);
			if (rows[i].wr) check("byte enables", {28'h0, be_seen}, {28'h0, ~rows[i].dqm});
			else if (rows[i].dqm == 4'h0) check("read word", d, arr[{2'h1, last}]);
		end
		axi_wr(REG_DQM, 32'h0, r);
		run(10'h027, OP_READ, 11'h000, 1'b1);
		check("page stop", 32'(col_q.size() < 256), 32'h1);
		run(10'h023, OP_READ, 11'h400, 1'b1);
		check("ap burst", 32'(col_q.size()), 32'h8);
		base = refs;
		for (int i = 0; i < 1700 && refs < base + 2; i++) @(posedge aclk);
		check("refreshes", 32'(refs >= base + 2), 32'h1);
		cmd(OP_SLEEP, 2'h0, 11'h000);
		check("power down", {30'h0, power_down, lk.cke}, 32'h2);
		cmd(OP_WAKE, 2'h0, 11'h000);
		check("power up", {31'h0, power_down}, 32'h0);
		cmd(OP_SELF, 2'h0, 11'h000);
		axi_rd(REG_STATUS, d, r);
		check("self refresh", {29'h0, self_ref, d[2:1]}, 32'h7);
		cmd(OP_WAKE, 2'h0, 11'h000);
		check("self exit", {31'h0, self_ref}, 32'h0);
		run(10'h022, OP_READ, 11'h020, 1'b0);
		expect_cols(10'h022, 8'h20, 1'b0, last);
		axi_wr(8'h20, 32'h1, r);
		check("bad write", {30'h0, r}, {30'h0, RESP_SLVERR});
		axi_rd(8'h24, d, r);
		check("bad read", {30'h0, r}, {30'h0, RESP_SLVERR});
		finish_test();
	end
endmodule : sdram_mode_refresh_power_cmds_tb_top
